// ==== core/fcct_top.sv ====
// Four channel down counter timer with daisy chain interrupts
`timescale 1ns/10ps
`default_nettype none
module fcct_top
   import fcct_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic channel_select_high,
   input wire logic channel_select_low,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic [3:0] count_trigger_in,
   output logic [2:0] zero_count_pulse_out,
   output logic int_req_n,
   input wire logic chain_priority_in,
   output logic chain_priority_out,
   input wire logic opcode_fetch_marker,
   input wire logic io_cycle_strobe
);
   import fcct_pkg::*;
   fcct_irq_if irq ();
   logic [1:0] sel;
   logic [4:0] vec_reg;
   logic [3:0] zs_reg;
   logic [3:0] ie_reg;
   logic [7:0] cnt_rd [NUM_CH];
   logic vec_valid;
   logic [7:0] vec_data;

   assign sel = {channel_select_high, channel_select_low};
   assign irq.zero_strobe = zs_reg;
   assign irq.irq_enable = ie_reg;
   assign irq.vector_high = vec_reg;

   // Vector base, written through channel 0 with bit 0 clear
   always_ff @(posedge core_clk)
   begin
      if (rst)
         vec_reg <= RST_VEC;
      else if (wr_strobe && sel == 2'd0 && !data_in[CW_IS_CTRL])
         vec_reg <= data_in[7:3];
   end

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      fcct_state_t st_reg;
      logic [7:0] cw_reg;
      logic [7:0] tc_reg;
      logic [7:0] cnt_reg;
      logic [7:0] pre_reg;
      logic trig_q_reg;
      logic edge_hit;
      logic tick;
      logic wr_me;
      logic follow_reg;
      logic [7:0] cw_new;

      assign wr_me = wr_strobe && sel == 2'(c);
      // Edge test uses the stored slope; rewriting the slope alone gives no edge
      assign edge_hit = cw_reg[CW_RISE] ? (count_trigger_in[c] && !trig_q_reg)
                                        : (!count_trigger_in[c] && trig_q_reg);
      assign tick = cw_reg[CW_TIMER]
                    ? (pre_reg == (cw_reg[CW_PRE256] ? PRE_DIV_HI_MAX : PRE_DIV_LO_MAX))
                    : edge_hit;
      assign cw_new = data_in;
      assign cnt_rd[c] = cnt_reg;

      always_ff @(posedge core_clk)
      begin
         if (rst)
            trig_q_reg <= 1'b0;
         else
            trig_q_reg <= count_trigger_in[c];
      end

      // Prescaler, held clear unless a timer is running
      always_ff @(posedge core_clk)
      begin
         if (rst || st_reg != FCCT_ST_RUN || !cw_reg[CW_TIMER])
            pre_reg <= 8'h00;
         else if (tick)
            pre_reg <= 8'h00;
         else
            pre_reg <= pre_reg + 8'h01;
      end

      always_ff @(posedge core_clk)
      begin
         if (rst)
         begin
            st_reg <= FCCT_ST_IDLE;
            cw_reg <= RST_BYTE;
            tc_reg <= RST_BYTE;
            cnt_reg <= RST_BYTE;
            follow_reg <= 1'b0;
            zs_reg[c] <= 1'b0;
            ie_reg[c] <= 1'b0;
         end
         else
         begin
            zs_reg[c] <= 1'b0;
            if (wr_me && follow_reg)
            begin
               tc_reg <= data_in;
               follow_reg <= 1'b0;
               if (st_reg != FCCT_ST_RUN)
               begin
                  cnt_reg <= data_in;
                  st_reg <= (cw_reg[CW_TIMER] && cw_reg[CW_EXT_TRIG])
                            ? FCCT_ST_WAIT_TRIG : FCCT_ST_RUN;
               end
            end
            else if (wr_me && data_in[CW_IS_CTRL])
            begin
               cw_reg <= cw_new;
               ie_reg[c] <= cw_new[CW_IRQ_EN];
               follow_reg <= cw_new[CW_TC_FOLLOWS];
               if (cw_new[CW_SOFT_RST])
                  st_reg <= cw_new[CW_TC_FOLLOWS] ? FCCT_ST_WAIT_TC : FCCT_ST_IDLE;
            end
            else if (st_reg == FCCT_ST_WAIT_TRIG && edge_hit)
               st_reg <= FCCT_ST_RUN;
            else if (st_reg == FCCT_ST_RUN && tick)
            begin
               // Reload in the zero cycle so no period is lost
               if (cnt_reg == 8'h01)
               begin
                  cnt_reg <= tc_reg;
                  zs_reg[c] <= 1'b1;
               end
               else
                  cnt_reg <= cnt_reg - 8'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         zero_count_pulse_out <= 3'h0;
      else
         zero_count_pulse_out <= zs_reg[2:0];
   end

   // Bus answer stands one cycle; a vector wins over a read in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         data_out <= RST_BYTE;
         data_oe <= 1'b0;
      end
      else
      begin
         data_oe <= rd_strobe || vec_valid;
         data_out <= vec_valid ? vec_data : cnt_rd[sel];
      end
   end

   fcct_chain u_chain (
      .core_clk(core_clk),
      .rst(rst),
      .irq(irq.chain),
      .chain_priority_in(chain_priority_in),
      .opcode_fetch_marker(opcode_fetch_marker),
      .io_cycle_strobe(io_cycle_strobe),
      .data_in(data_in),
      .chain_priority_out(chain_priority_out),
      .int_req_n(int_req_n),
      .vec_valid(vec_valid),
      .vec_data(vec_data)
   );
endmodule : fcct_top
`default_nettype wire

// ==== core/fcct_pkg.sv ====
// Package of constants and types for the four channel counter timer
// ----------------------------------------
// Summary of operation
// ----------------------------------------
// Summary of operation
// - Host programs each channel with a control word, then a time constant.
// - Control word decodes to irq enable, mode, prescale, edge, trigger, follow, reset.
// - Timer mode prescaler divides clock by 16 or 256, chosen by bit 5.
// - Timer mode decrements counter once per prescaler tick.
// - Counter mode decrements once per active trigger edge, clock synchronised.
// - Time constant is 8 bits; zero stands for 256.
// - Counter loads constant at start and again at every zero.
// - Timer starts at constant write or on trigger edge, as chosen.
// - Channels 0 to 2 pulse their zero count output high at zero.
// - Channel 3 has no zero count output; only its interrupt.
// - Enabled channels raise active low service request at zero, held off while chain input low or a channel in service.
// - Each channel holds its own interrupt enable.
// - Channel 0 has highest internal priority, channel 3 lowest.
// - On acknowledge the winning channel's vector goes onto the data bus.
// - Priority held only while chain input high; chain out low otherwise.
// - Pending or in-service interrupt holds chain output low.
// - On first return opcode byte with pending request, chain out high one cycle.
// - Reading a channel returns live count without disturbing it.
// - Bit 0 set marks control word; bit 2 says constant follows.
// - Bits 7,6,5,4,3,1 are irq enable, mode, prescale, edge, trigger, reset.
// - Bit 0 clear to channel 0 stores vector bits 7..3; bits 2..1 name channel.
package fcct_pkg;
   localparam int NUM_CH = 4;
   localparam int CW_IRQ_EN = 7;
   localparam int CW_TIMER = 6;
   localparam int CW_PRE256 = 5;
   localparam int CW_RISE = 4;
   localparam int CW_EXT_TRIG = 3;
   localparam int CW_TC_FOLLOWS = 2;
   localparam int CW_SOFT_RST = 1;
   localparam int CW_IS_CTRL = 0;
   localparam logic [7:0] PRE_DIV_LO_MAX = 8'h0f;
   localparam logic [7:0] PRE_DIV_HI_MAX = 8'hff;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_VEC = 5'h00;
   localparam logic [7:0] RET_PREFIX = 8'hed;
   localparam logic [7:0] RET_SECOND = 8'h4d;
   typedef enum {FCCT_ST_IDLE, FCCT_ST_WAIT_TC, FCCT_ST_WAIT_TRIG, FCCT_ST_RUN} fcct_state_t;
endpackage : fcct_pkg

// ==== core/fcct_irq_if.sv ====
// Interface carrying channel zero strobes, interrupt enables and vector base to the daisy chain unit
`timescale 1ns/10ps
`default_nettype none
interface fcct_irq_if;
   logic [3:0] zero_strobe;
   logic [3:0] irq_enable;
   logic [4:0] vector_high;
   modport chan (output zero_strobe, output irq_enable, output vector_high);
   modport chain (input zero_strobe, input irq_enable, input vector_high);
endinterface : fcct_irq_if
`default_nettype wire

// ==== core/fcct_chain.sv ====
// Daisy chain interrupt unit with vector generation
`timescale 1ns/10ps
`default_nettype none
module fcct_chain
   import fcct_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   fcct_irq_if.chain irq,
   input wire logic chain_priority_in,
   input wire logic opcode_fetch_marker,
   input wire logic io_cycle_strobe,
   input wire logic [7:0] data_in,
   output logic chain_priority_out,
   output logic int_req_n,
   output logic vec_valid,
   output logic [7:0] vec_data
);
   import fcct_pkg::*;
   logic [3:0] pend_reg;
   logic [3:0] serv_reg;
   logic [1:0] win;
   logic any_win;
   logic ret_prefix_reg;
   logic ret_lift;
   logic ack;
   logic fetch_q_reg;
   logic fetch_start;

   assign ack = opcode_fetch_marker && io_cycle_strobe;
   assign fetch_start = opcode_fetch_marker && !fetch_q_reg && !io_cycle_strobe;
   assign ret_lift = fetch_start && (data_in == RET_PREFIX) && (pend_reg != 4'h0);

   // ----------------------------------------
   // Priority pick
   // ----------------------------------------
   always_comb
   begin
      win = 2'd3;
      any_win = 1'b0;
      for (int i = NUM_CH - 1; i >= 0; i--)
      begin
         if (pend_reg[i])
         begin
            win = 2'(i);
            any_win = 1'b1;
         end
      end
   end

   // Pending set wins over the acknowledge clear
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pend_reg <= 4'h0;
         serv_reg <= 4'h0;
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (irq.zero_strobe[i] && irq.irq_enable[i])
               pend_reg[i] <= 1'b1;
            else if (!irq.irq_enable[i])
               pend_reg[i] <= 1'b0;
            else if (ack && chain_priority_in && any_win && win == 2'(i))
               pend_reg[i] <= 1'b0;
         end
         if (ack && chain_priority_in && any_win)
            serv_reg[win] <= 1'b1;
         else if (fetch_start && ret_prefix_reg && data_in == RET_SECOND)
         begin
            for (int i = NUM_CH - 1; i >= 0; i--)
               if (serv_reg[i])
                  serv_reg <= serv_reg & ~(4'h1 << i);
         end
      end
   end

   // ----------------------------------------
   // Return opcode decoding
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ret_prefix_reg <= 1'b0;
         fetch_q_reg <= 1'b0;
      end
      else
      begin
         fetch_q_reg <= opcode_fetch_marker;
         // Prefix is kept until the next fetch, so the second byte still sees it
         if (fetch_start)
            ret_prefix_reg <= (data_in == RET_PREFIX);
      end
   end

   // Vector is combinational here; the top registers it onto its pins
   always_comb
   begin
      vec_valid = ack && chain_priority_in && any_win;
      vec_data = {irq.vector_high, win, 1'b0};
   end

   // ----------------------------------------
   // Chain output and interrupt request
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         chain_priority_out <= 1'b0;
         int_req_n <= 1'b1;
      end
      else
      begin
         if (!chain_priority_in)
            chain_priority_out <= 1'b0;
         else if (ret_lift)
            chain_priority_out <= 1'b1;
         else
            chain_priority_out <= (pend_reg == 4'h0) && (serv_reg == 4'h0);
         int_req_n <= !(chain_priority_in && (pend_reg != 4'h0) && (serv_reg == 4'h0));
      end
   end
endmodule : fcct_chain
`default_nettype wire

// ==== verif/fcct_chk.sv ====
// Checker of port timing rules for the counter timer
`timescale 1ns/10ps
`default_nettype none
module fcct_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic rd_strobe,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic [2:0] zero_count_pulse_out,
   input wire logic int_req_n,
   input wire logic chain_priority_in,
   input wire logic chain_priority_out,
   input wire logic opcode_fetch_marker,
   input wire logic io_cycle_strobe
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence s_ack;
      opcode_fetch_marker && io_cycle_strobe;
   endsequence
   property p_read_ans;
      rd_strobe |=> data_oe;
   endproperty
   a_read_ans: assert property (p_read_ans) else $error("read answer missing");
   property p_ack_vec;
      s_ack |=> data_oe && (data_out[0] == 1'b0);
   endproperty
   a_ack_vec: assert property (p_ack_vec) else $error("vector missing");
   property p_vec_stands;
      s_ack ##1 (!rd_strobe && !(opcode_fetch_marker && io_cycle_strobe)) |=> !data_oe;
   endproperty
   a_vec_stands: assert property (p_vec_stands) else $error("vector held too long");
   property p_oe_cause;
      data_oe |-> $past(rd_strobe) || $past(opcode_fetch_marker && io_cycle_strobe);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("bus driven without cause");
   property p_zc_one;
      (zero_count_pulse_out & $past(zero_count_pulse_out)) == 3'h0;
   endproperty
   a_zc_one: assert property (p_zc_one) else $error("zero pulse too long");
   property p_chain_blk;
      !chain_priority_in |=> !chain_priority_out;
   endproperty
   a_chain_blk: assert property (p_chain_blk) else $error("chain out not blocked");
   property p_req_prio;
      $fell(int_req_n) |-> chain_priority_in || $past(chain_priority_in);
   endproperty
   a_req_prio: assert property (p_req_prio) else $error("request without priority");
   // The return prefix may lift chain out while pending, so fetch cycles are left out
   property p_pend_low;
      !int_req_n && !$past(int_req_n) && !opcode_fetch_marker && !$past(opcode_fetch_marker)
         |-> !chain_priority_out;
   endproperty
   a_pend_low: assert property (p_pend_low) else $error("chain out high while pending");
   property p_rst_idle;
      $fell(rst) |-> int_req_n && !data_oe && (zero_count_pulse_out == 3'h0);
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");
   property p_ret_lift;
      opcode_fetch_marker && !$past(opcode_fetch_marker) && !io_cycle_strobe
         && (data_in == 8'hed) && !int_req_n && chain_priority_in |=> chain_priority_out;
   endproperty
   a_ret_lift: assert property (p_ret_lift) else $error("chain out not lifted on return");
endmodule : fcct_chk
bind fcct_top fcct_chk i_chk (.core_clk, .rst, .rd_strobe, .data_in, .data_out, .data_oe,
   .zero_count_pulse_out, .int_req_n, .chain_priority_in, .chain_priority_out,
   .opcode_fetch_marker, .io_cycle_strobe);
`default_nettype wire

// ==== verif/fcct_host.sv ====
// Host model driving the counter timer bus
`timescale 1ns/10ps
`default_nettype none
module fcct_host (
   input wire logic core_clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output var logic channel_select_high,
   output var logic channel_select_low,
   output var logic wr_strobe,
   output var logic rd_strobe,
   output var logic [7:0] data_in,
   output var logic [3:0] count_trigger_in,
   output var logic chain_priority_in,
   output var logic opcode_fetch_marker,
   output var logic io_cycle_strobe
);
   initial
   begin
      {channel_select_high, channel_select_low} = 2'h0;
      {wr_strobe, rd_strobe, opcode_fetch_marker, io_cycle_strobe} = 4'h0;
      data_in = 8'h00;
      count_trigger_in = 4'h0;
      chain_priority_in = 1'b1;
   end
   // Released data lines show the inverse so a stale byte never passes as fresh
   task automatic put(input logic [1:0] ch, input logic [7:0] v);
      @(negedge core_clk);
      {channel_select_high, channel_select_low} = ch;
      data_in = v;
      wr_strobe = 1'b1;
      @(negedge core_clk);
      wr_strobe = 1'b0;
      data_in = ~v;
   endtask : put
   task automatic get(input logic [1:0] ch, output logic [7:0] v, output logic oe);
      @(negedge core_clk);
      {channel_select_high, channel_select_low} = ch;
      rd_strobe = 1'b1;
      @(negedge core_clk);
      rd_strobe = 1'b0;
      v = data_out;
      oe = data_oe;
   endtask : get
   task automatic ack(output logic [7:0] v, output logic oe);
      @(negedge core_clk);
      opcode_fetch_marker = 1'b1;
      io_cycle_strobe = 1'b1;
      @(negedge core_clk);
      {opcode_fetch_marker, io_cycle_strobe} = 2'h0;
      v = data_out;
      oe = data_oe;
   endtask : ack
   task automatic fetch(input logic [7:0] op);
      @(negedge core_clk);
      opcode_fetch_marker = 1'b1;
      data_in = op;
      @(negedge core_clk);
      opcode_fetch_marker = 1'b0;
      data_in = ~op;
   endtask : fetch
   task automatic pulse(input int ch);
      @(negedge core_clk);
      count_trigger_in[ch] = 1'b1;
      repeat (3) @(negedge core_clk);
      count_trigger_in[ch] = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : pulse
   task automatic set_chain(input logic b);
      @(negedge core_clk);
      chain_priority_in = b;
   endtask : set_chain
endmodule : fcct_host
`default_nettype wire

// ==== verif/fcct_test.sv ====
// Self-checking bench for the four channel counter timer
`timescale 1ns/10ps
`default_nettype none
module fcct_test;
   import fcct_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic channel_select_high, channel_select_low, wr_strobe, rd_strobe, data_oe, int_req_n;
   logic chain_priority_in, chain_priority_out, opcode_fetch_marker, io_cycle_strobe;
   logic [7:0] data_in, data_out;
   logic [3:0] count_trigger_in;
   logic [2:0] zero_count_pulse_out;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int zc_cnt [3] = '{0, 0, 0};
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      for (int i = 0; i < 3; i++)
         zc_cnt[i] += int'(zero_count_pulse_out[i] === 1'b1);
   end
   fcct_top i_dut (.core_clk, .rst, .channel_select_high, .channel_select_low, .wr_strobe,
      .rd_strobe, .data_in, .data_out, .data_oe, .count_trigger_in, .zero_count_pulse_out,
      .int_req_n, .chain_priority_in, .chain_priority_out, .opcode_fetch_marker,
      .io_cycle_strobe);
   fcct_host i_host (.core_clk, .data_out, .data_oe, .channel_select_high,
      .channel_select_low, .wr_strobe, .rd_strobe, .data_in, .count_trigger_in,
      .chain_priority_in, .opcode_fetch_marker, .io_cycle_strobe);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic wait_zc(input int i, output int t);
      for (int k = 0; k < 600; k++)
      begin
         @(negedge core_clk);
         if (zero_count_pulse_out[i] === 1'b1)
            break;
      end
      t = cyc;
   endtask : wait_zc
   task automatic t_reset;
      chk(16'(int_req_n), 16'h0001);
      chk(16'(data_oe), 16'h0000);
      chk(16'(zero_count_pulse_out), 16'h0000);
      i_host.set_chain(1'b0);
      repeat (2) @(negedge core_clk);
      chk(16'(chain_priority_out), 16'h0000);
      i_host.set_chain(1'b1);
      repeat (2) @(negedge core_clk);
      chk(16'(chain_priority_out), 16'h0001);
      $display("test reset done");
   endtask : t_reset
   task automatic t_counter;
      logic [7:0] v;
      logic oe;
      int z;
      i_host.put(2'h1, 8'h15);
      i_host.put(2'h1, 8'h03);
      i_host.get(2'h1, v, oe);
      chk(16'(v), 16'h0003);
      chk(16'(oe), 16'h0001);
      z = zc_cnt[1];
      i_host.pulse(1);
      i_host.get(2'h1, v, oe);
      chk(16'(v), 16'h0002);
      i_host.pulse(1);
      i_host.pulse(1);
      chk(16'(zc_cnt[1] - z), 16'h0001);
      i_host.get(2'h1, v, oe);
      chk(16'(v), 16'h0003);
      chk(16'(int_req_n), 16'h0001);
      $display("test counter done");
   endtask : t_counter
   task automatic t_timer;
      int a, b;
      i_host.put(2'h0, 8'h45);
      i_host.put(2'h0, 8'h02);
      wait_zc(0, a);
      wait_zc(0, b);
      chk(16'(b - a), 16'h0020);
      i_host.put(2'h0, 8'h67);
      i_host.put(2'h0, 8'h01);
      wait_zc(0, a);
      wait_zc(0, b);
      chk(16'(b - a), 16'h0100);
      i_host.put(2'h0, 8'h03);
      $display("test timer done");
   endtask : t_timer
   task automatic t_trig;
      int a, b, z;
      i_host.put(2'h2, 8'h5d);
      i_host.put(2'h2, 8'h01);
      z = zc_cnt[2];
      repeat (40) @(negedge core_clk);
      chk(16'(zc_cnt[2] - z), 16'h0000);
      i_host.pulse(2);
      wait_zc(2, a);
      wait_zc(2, b);
      chk(16'(b - a), 16'h0010);
      i_host.put(2'h2, 8'h03);
      $display("test trigger done");
   endtask : t_trig
   task automatic t_irq;
      logic [7:0] v;
      logic oe;
      int z;
      z = zc_cnt[0] + zc_cnt[1] + zc_cnt[2];
      i_host.put(2'h0, 8'h40);
      i_host.put(2'h3, 8'h95);
      i_host.put(2'h3, 8'h01);
      i_host.pulse(3);
      chk(16'(int_req_n), 16'h0000);
      chk(16'(chain_priority_out), 16'h0000);
      chk(16'(zc_cnt[0] + zc_cnt[1] + zc_cnt[2] - z), 16'h0000);
      i_host.fetch(RET_PREFIX);
      chk(16'(chain_priority_out), 16'h0001);
      i_host.ack(v, oe);
      chk(16'(v), 16'h0046);
      chk(16'(oe), 16'h0001);
      i_host.put(2'h3, 8'h03);
      i_host.fetch(RET_PREFIX);
      i_host.fetch(RET_SECOND);
      repeat (2) @(negedge core_clk);
      chk(16'(int_req_n), 16'h0001);
      chk(16'(chain_priority_out), 16'h0001);
      $display("test interrupt done");
   endtask : t_irq
   initial
   begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      t_reset();
      t_counter();
      t_timer();
      t_trig();
      t_irq();
      final_report();
   end
   // Whole run needs under 2000 cycles; the margin covers slow trigger sync
   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      final_report();
   end
endmodule : fcct_test
`default_nettype wire
